// ==== ucj_pkg.sv ====
// Constants, field layouts and carrier types of the conditional jump unit.
// Assumes a 16-bit instruction word and a code RAM address of CODE_ADDR_W bits.
package ucj_pkg;

  localparam int CODE_ADDR_W = 10;
  localparam int INSTR_W     = 16;
  localparam int CTRL_W      = 16;
  localparam int AVS_AW      = 12;
  localparam int AVS_DW      = 32;
  localparam int REG_IDX_W   = 10;

  // Opcode fields and their positions.
  localparam logic [6:0] ABS_FLAG_OPC  = 7'h1D;
  localparam logic [6:0] REL_FLAG_OPC  = 7'h12;
  localparam logic [5:0] ABS_CTRL_OPC  = 6'h0F;
  localparam logic [3:0] ABS_FLAG_TAIL = 4'h5;
  localparam logic [3:0] ABS_CTRL_TAIL = 4'h4;
  localparam int OPC_HI    = 15;
  localparam int OPC7_LO   = 9;
  localparam int OPC6_LO   = 10;
  localparam int POL_POS   = 9;
  localparam int SEL_HI    = 8;
  localparam int SEL_LO    = 5;
  localparam int JREG_POS  = 4;
  localparam int OFF_HI    = 4;
  localparam int OFF_W     = 5;
  localparam int TAIL_HI   = 3;

  // Register indices; the byte address is four times the index.
  localparam logic [REG_IDX_W-1:0] IDX_CORE0_WORD_A = 10'h101;
  localparam logic [REG_IDX_W-1:0] IDX_CORE1_WORD_A = 10'h102;
  localparam logic [REG_IDX_W-1:0] IDX_CORE0_WORD_B = 10'h121;
  localparam logic [REG_IDX_W-1:0] IDX_CORE1_WORD_B = 10'h122;
  localparam logic [REG_IDX_W-1:0] IDX_JUMP_STATUS  = 10'h140;
  localparam logic [CTRL_W-1:0]    CTRL_WORD_RST    = 16'h0000;

  // Jump status register fields.
  localparam int ST_TAKEN_POS   = 0;
  localparam int ST_DECODED_POS = 1;
  localparam int ST_KIND_LO     = 2;
  localparam int ST_TARGET_LO   = 16;

  typedef enum logic [3:0] {
    FS_OP_DONE   = 4'h0,
    FS_SGN_OVER  = 4'h1,
    FS_SGN_UNDER = 4'h2,
    FS_UNS_OVER  = 4'h3,
    FS_UNS_UNDER = 4'h4,
    FS_SIGN      = 4'h5,
    FS_ZERO      = 4'h6,
    FS_MUL_LOSS  = 4'h7,
    FS_MUL_OVER  = 4'h8,
    FS_MASK_ONES = 4'h9,
    FS_MASK_ZERO = 4'hA,
    FS_ARITH_A0  = 4'hB,
    FS_ARITH_A1  = 4'hC,
    FS_CARRY     = 4'hD,
    FS_CONV_SIGN = 4'hE,
    FS_SHIFT_CY  = 4'hF
  } ucj_flag_sel_type;

  // ALU condition register, last listed flag in the least significant bit.
  typedef struct packed {
    logic shiftCarry;
    logic convSign;
    logic carry;
    logic arithA1;
    logic arithA0;
    logic maskZero;
    logic maskOnes;
    logic mulOver;
    logic mulLoss;
    logic resultZero;
    logic resultSign;
    logic unsUnder;
    logic unsOver;
    logic sgnUnder;
    logic sgnOver;
    logic opDone;
  } ucj_alu_flags_type;

  typedef enum logic [1:0] {
    KIND_NONE     = 2'b00,
    KIND_ABS_FLAG = 2'b01,
    KIND_REL_FLAG = 2'b10,
    KIND_ABS_CTRL = 2'b11
  } ucj_kind_type;

  typedef struct packed {
    logic                   valid;
    logic [INSTR_W-1:0]     word;
    logic [CODE_ADDR_W-1:0] addr;
  } ucj_instr_type;

  typedef struct packed {
    logic [CODE_ADDR_W-1:0] jump1;
    logic [CODE_ADDR_W-1:0] jump0;
  } ucj_jump_regs_type;

  typedef struct packed {
    logic                   valid;
    logic                   taken;
    ucj_kind_type           kind;
    logic [CODE_ADDR_W-1:0] next;
  } ucj_pc_update_type;

endpackage

// ==== ucj_cond_eval.sv ====
// Condition evaluator: picks an ALU flag and tests a control-word bit.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module ucj_cond_eval
  import ucj_pkg::*;
(
  // Flag test
  input  wire ucj_alu_flags_type aluFlags,
  input  wire logic [3:0]        flagSel,
  output logic                   flagTrue,
  // Control-word bit test
  input  wire logic [CTRL_W-1:0] ctrlWord,
  input  wire logic [3:0]        ctrlSel,
  input  wire logic              ctrlPol,
  output logic                   ctrlTrue
);

  logic [CTRL_W-1:0] bitHit;

  always_comb begin
    case (ucj_flag_sel_type'(flagSel))
      FS_OP_DONE:   flagTrue = aluFlags.opDone;     // RULE_02
      FS_SGN_OVER:  flagTrue = aluFlags.sgnOver;    // RULE_02
      FS_SGN_UNDER: flagTrue = aluFlags.sgnUnder;   // RULE_02
      FS_UNS_OVER:  flagTrue = aluFlags.unsOver;    // RULE_02
      FS_UNS_UNDER: flagTrue = aluFlags.unsUnder;   // RULE_02
      FS_SIGN:      flagTrue = aluFlags.resultSign; // RULE_03
      FS_ZERO:      flagTrue = aluFlags.resultZero; // RULE_03
      FS_MUL_LOSS:  flagTrue = aluFlags.mulLoss;    // RULE_03
      FS_MUL_OVER:  flagTrue = aluFlags.mulOver;    // RULE_03
      FS_MASK_ONES: flagTrue = aluFlags.maskOnes;   // RULE_04
      FS_MASK_ZERO: flagTrue = aluFlags.maskZero;   // RULE_04
      FS_ARITH_A0:  flagTrue = aluFlags.arithA0;    // RULE_04
      FS_ARITH_A1:  flagTrue = aluFlags.arithA1;    // RULE_04
      FS_CARRY:     flagTrue = aluFlags.carry;      // RULE_04
      FS_CONV_SIGN: flagTrue = aluFlags.convSign;   // RULE_04
      FS_SHIFT_CY:  flagTrue = aluFlags.shiftCarry; // RULE_04
      default:      flagTrue = 1'b0;
    endcase
  end

  for (genvar i = 0; i < CTRL_W; i++) begin : gBit
    // Bit i counts only when selected and equal to the chosen polarity.
    assign bitHit[i] = (ctrlSel == 4'(i)) && (ctrlWord[i] == ctrlPol); // RULE_10 RULE_11
  end

  assign ctrlTrue = |bitHit;

endmodule

// ==== ucj_jump_unit.sv ====
// Conditional jump unit: decodes the three conditional jumps and computes
// the next program counter, with control words reachable over Avalon-MM.
// Assumes the fetch path presents one instruction per valid cycle and that
// jump registers and ALU flags are stable while the instruction is valid.
`timescale 1ns/1ps

// Notes on behaviour
// (RULE_01) Flag true: absolute jump to selected jump register.
// (RULE_02) Codes 0-4: done, sgnOver, sgnUnder, unsOver, unsUnder.
// (RULE_03) Codes 5-8: sign, zero, mulLoss, mulOver.
// (RULE_04) Codes 9-15: maskOnes, maskZero, A0, A1, carry, conv, shift.
// (RULE_05) Flag true: relative jump from current address.
// (RULE_06) Offset is 5-bit two's complement, -16..15.
// (RULE_07) Absolute flag jump: 0011101, sel, reg, 0101.
// (RULE_08) Relative flag jump: 0010010, sel, offset.
// (RULE_09) Control bit matches: absolute jump via jump register.
// (RULE_10) Select n tests control word bit n.
// (RULE_11) Polarity 0 wants zero, 1 wants one.
// (RULE_12) Absolute control jump: 001111, pol, sel, 0100.
// (RULE_13) False condition: continue at next address.
// (RULE_14) Control jump takes register operand from bit 4.
module ucj_jump_unit
  import ucj_pkg::*;
#(
  parameter int CORE_ID = 0
)
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Instruction from fetch and condition sources
  input  wire ucj_instr_type          instrIn,
  input  wire ucj_alu_flags_type      aluFlags,
  input  wire ucj_jump_regs_type      jumpRegs,
  // Program counter update
  output ucj_pc_update_type           pcUpdate,
  // Avalon-MM slave
  input  wire logic [AVS_AW-1:0]      avsAddress,
  input  wire logic                   avsRead,
  input  wire logic                   avsWrite,
  input  wire logic [AVS_DW-1:0]      avsWritedata,
  input  wire logic [AVS_DW/8-1:0]    avsByteenable,
  output logic [AVS_DW-1:0]           avsReaddata,
  output logic                        avsWaitrequest
);

  // Decode.
  logic                   isAbsFlag;
  logic                   isRelFlag;
  logic                   isAbsCtrl;
  logic                   flagTrue;
  logic                   ctrlTrue;
  logic [CTRL_W-1:0]      testedWord;
  logic [CODE_ADDR_W-1:0] seqAddr;
  logic [CODE_ADDR_W-1:0] relAddr;
  logic [CODE_ADDR_W-1:0] jregAddr;
  logic [OFF_W-1:0]       offset;

  // Decision state.
  ucj_pc_update_type      pcUpdate_r;
  ucj_pc_update_type      pcUpdate_nxt;
  logic                   lastTaken_r;
  logic                   lastTaken_nxt;
  logic                   lastDecoded_r;
  logic                   lastDecoded_nxt;
  ucj_kind_type           lastKind_r;
  ucj_kind_type           lastKind_nxt;
  logic [CODE_ADDR_W-1:0] lastTarget_r;
  logic [CODE_ADDR_W-1:0] lastTarget_nxt;

  // Control words.
  logic [CTRL_W-1:0]      core0WordA_r;
  logic [CTRL_W-1:0]      core0WordA_nxt;
  logic [CTRL_W-1:0]      core1WordA_r;
  logic [CTRL_W-1:0]      core1WordA_nxt;
  logic [CTRL_W-1:0]      core0WordB_r;
  logic [CTRL_W-1:0]      core0WordB_nxt;
  logic [CTRL_W-1:0]      core1WordB_r;
  logic [CTRL_W-1:0]      core1WordB_nxt;

  // Bus state.
  logic                   waitReq_r;
  logic                   waitReq_nxt;
  logic [AVS_DW-1:0]      readData_r;
  logic [AVS_DW-1:0]      readData_nxt;
  logic                   busReq;
  logic                   busCommit;
  logic [REG_IDX_W-1:0]   regIdx;
  logic                   aligned;

  assign isAbsFlag = (instrIn.word[OPC_HI:OPC7_LO] == ABS_FLAG_OPC)
                  && (instrIn.word[TAIL_HI:0] == ABS_FLAG_TAIL);   // RULE_07
  assign isRelFlag = (instrIn.word[OPC_HI:OPC7_LO] == REL_FLAG_OPC); // RULE_08
  assign isAbsCtrl = (instrIn.word[OPC_HI:OPC6_LO] == ABS_CTRL_OPC)
                  && (instrIn.word[TAIL_HI:0] == ABS_CTRL_TAIL);   // RULE_12

  // Each core tests its own first control word; the second is storage only.
  assign testedWord = (CORE_ID == 0) ? core0WordA_r : core1WordA_r;

  ucj_cond_eval uCond (
    .aluFlags (aluFlags),
    .flagSel  (instrIn.word[SEL_HI:SEL_LO]),
    .flagTrue (flagTrue),
    .ctrlWord (testedWord),
    .ctrlSel  (instrIn.word[SEL_HI:SEL_LO]),
    .ctrlPol  (instrIn.word[POL_POS]),
    .ctrlTrue (ctrlTrue)
  );

  assign offset   = instrIn.word[OFF_HI:0];
  assign seqAddr  = instrIn.addr + CODE_ADDR_W'(1);
  // Sign extension wraps within the code RAM, as the fetch counter does.
  assign relAddr  = instrIn.addr
                  + {{(CODE_ADDR_W-OFF_W){offset[OFF_W-1]}}, offset}; // RULE_05 RULE_06
  // Both absolute forms read the register operand from the same bit.
  assign jregAddr = instrIn.word[JREG_POS] ? jumpRegs.jump1 : jumpRegs.jump0; // RULE_14

  always_comb begin
    pcUpdate_nxt       = '0;
    pcUpdate_nxt.kind  = KIND_NONE;
    lastTaken_nxt      = lastTaken_r;
    lastDecoded_nxt    = lastDecoded_r;
    lastKind_nxt       = lastKind_r;
    lastTarget_nxt     = lastTarget_r;
    if (instrIn.valid) begin
      pcUpdate_nxt.valid = 1'b1;
      pcUpdate_nxt.next  = seqAddr; // RULE_13
      if (isAbsFlag) begin
        pcUpdate_nxt.kind = KIND_ABS_FLAG;
        if (flagTrue) begin
          pcUpdate_nxt.taken = 1'b1;
          pcUpdate_nxt.next  = jregAddr; // RULE_01
        end
      end else if (isRelFlag) begin
        pcUpdate_nxt.kind = KIND_REL_FLAG;
        if (flagTrue) begin
          pcUpdate_nxt.taken = 1'b1;
          pcUpdate_nxt.next  = relAddr; // RULE_05
        end
      end else if (isAbsCtrl) begin
        pcUpdate_nxt.kind = KIND_ABS_CTRL;
        if (ctrlTrue) begin
          pcUpdate_nxt.taken = 1'b1;
          pcUpdate_nxt.next  = jregAddr; // RULE_09
        end
      end
      if (pcUpdate_nxt.kind != KIND_NONE) begin
        lastDecoded_nxt = 1'b1;
        lastTaken_nxt   = pcUpdate_nxt.taken;
        lastKind_nxt    = pcUpdate_nxt.kind;
        lastTarget_nxt  = pcUpdate_nxt.next;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pcUpdate_r    <= '0;
      lastTaken_r   <= 1'b0;
      lastDecoded_r <= 1'b0;
      lastKind_r    <= KIND_NONE;
      lastTarget_r  <= '0;
    end else begin
      pcUpdate_r    <= pcUpdate_nxt;
      lastTaken_r   <= lastTaken_nxt;
      lastDecoded_r <= lastDecoded_nxt;
      lastKind_r    <= lastKind_nxt;
      lastTarget_r  <= lastTarget_nxt;
    end
  end

  assign pcUpdate = pcUpdate_r;

  // Bus slave: waitrequest stays high in the first request cycle and drops
  // for exactly one cycle; the write commits and read data stands then.
  assign busReq    = avsRead || avsWrite;
  assign busCommit = busReq && !waitReq_r;
  assign regIdx    = avsAddress[AVS_AW-1:2];
  assign aligned   = (avsAddress[1:0] == 2'b00);

  function automatic logic [CTRL_W-1:0] mergeLanes(
    input logic [CTRL_W-1:0] oldVal,
    input logic [AVS_DW-1:0] wdata,
    input logic [AVS_DW/8-1:0] be
  );
    logic [CTRL_W-1:0] res;
    res = oldVal;
    if (be[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

  always_comb begin
    waitReq_nxt    = !(busReq && waitReq_r);
    readData_nxt   = readData_r;
    core0WordA_nxt = core0WordA_r;
    core1WordA_nxt = core1WordA_r;
    core0WordB_nxt = core0WordB_r;
    core1WordB_nxt = core1WordB_r;
    if (avsRead && waitReq_r) begin
      readData_nxt = '0;
      if (aligned) begin
        case (regIdx)
          IDX_CORE0_WORD_A: readData_nxt[CTRL_W-1:0] = core0WordA_r;
          IDX_CORE1_WORD_A: readData_nxt[CTRL_W-1:0] = core1WordA_r;
          IDX_CORE0_WORD_B: readData_nxt[CTRL_W-1:0] = core0WordB_r;
          IDX_CORE1_WORD_B: readData_nxt[CTRL_W-1:0] = core1WordB_r;
          IDX_JUMP_STATUS: begin
            readData_nxt[ST_TAKEN_POS]   = lastTaken_r;
            readData_nxt[ST_DECODED_POS] = lastDecoded_r;
            readData_nxt[ST_KIND_LO +: 2] = lastKind_r;
            readData_nxt[ST_TARGET_LO +: CODE_ADDR_W] = lastTarget_r;
          end
          default: readData_nxt = '0;
        endcase
      end
    end
    if (avsWrite && busCommit && aligned) begin
      case (regIdx)
        IDX_CORE0_WORD_A: core0WordA_nxt = mergeLanes(core0WordA_r, avsWritedata, avsByteenable);
        IDX_CORE1_WORD_A: core1WordA_nxt = mergeLanes(core1WordA_r, avsWritedata, avsByteenable);
        IDX_CORE0_WORD_B: core0WordB_nxt = mergeLanes(core0WordB_r, avsWritedata, avsByteenable);
        IDX_CORE1_WORD_B: core1WordB_nxt = mergeLanes(core1WordB_r, avsWritedata, avsByteenable);
        default: core0WordA_nxt = core0WordA_r;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      waitReq_r    <= 1'b1;
      readData_r   <= '0;
      core0WordA_r <= CTRL_WORD_RST;
      core1WordA_r <= CTRL_WORD_RST;
      core0WordB_r <= CTRL_WORD_RST;
      core1WordB_r <= CTRL_WORD_RST;
    end else begin
      waitReq_r    <= waitReq_nxt;
      readData_r   <= readData_nxt;
      core0WordA_r <= core0WordA_nxt;
      core1WordA_r <= core1WordA_nxt;
      core0WordB_r <= core0WordB_nxt;
      core1WordB_r <= core1WordB_nxt;
    end
  end

  assign avsReaddata    = readData_r;
  assign avsWaitrequest = waitReq_r;

endmodule

// ==== ucj_fetch_model.sv ====
// Fetch-side model: code RAM word, its address and the valid strobe.
// Assumes the bench updates cmd by non-blocking assignment after a rising edge.
`timescale 1ns/1ps
module ucj_fetch_model
  import ucj_pkg::*;
(
  // Clock
  input  wire logic          clk,
  // Command from the bench
  input  wire ucj_instr_type cmd,
  // Fetch output
  output ucj_instr_type      instrIn
);
  ucj_instr_type last_r = '0;

  always_ff @(posedge clk) begin
    if (cmd.valid) begin
      last_r <= cmd;
    end
  end

  // Idle cycles show the inverse of the last word, so a stale fetch is never mistaken for a hold.
  assign instrIn = cmd.valid ? cmd : ucj_instr_type'{1'b0, ~last_r.word, ~last_r.addr};
endmodule

// ==== ucj_jump_unit_assertions.sv ====
// Checker for the conditional jump unit, bound to ucj_jump_unit.
// Assumes jump registers and ALU flags are stable while an instruction is valid.
`timescale 1ns/1ps
module ucj_jump_unit_assertions
  import ucj_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              sys_rst,
  // Instruction path
  input wire ucj_instr_type     instrIn,
  input wire ucj_alu_flags_type aluFlags,
  input wire ucj_jump_regs_type jumpRegs,
  input wire ucj_pc_update_type pcUpdate,
  // Avalon-MM
  input wire logic [AVS_AW-1:0] avsAddress,
  input wire logic              avsRead,
  input wire logic              avsWrite,
  input wire logic [AVS_DW-1:0] avsWritedata,
  input wire logic [3:0]        avsByteenable,
  input wire logic [AVS_DW-1:0] avsReaddata,
  input wire logic              avsWaitrequest
);
  logic [15:0] w;
  logic [15:0] fl;
  logic        absF;
  logic        relF;
  logic        absC;
  logic        flagBit;
  logic [9:0]  jreg;
  logic [9:0]  relNext;

  assign w       = instrIn.word;
  assign fl      = aluFlags;
  assign flagBit = fl[w[8:5]];
  assign absF    = instrIn.valid && w[15:9] == 7'h1D && w[3:0] == 4'h5;
  assign relF    = instrIn.valid && w[15:9] == 7'h12;
  assign absC    = instrIn.valid && w[15:10] == 6'h0F && w[3:0] == 4'h4;
  assign jreg    = w[4] ? jumpRegs.jump1 : jumpRegs.jump0;
  assign relNext = instrIn.addr + {{5{w[4]}}, w[4:0]};

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_abs_flag_take: assert property (absF && flagBit |=> pcUpdate.taken && pcUpdate.next == $past(jreg))
    else $error("absolute flag jump missed its target");
  a_flag_low_codes: assert property ((absF || relF) && w[8:5] <= 4'h4 |=> pcUpdate.taken == $past(flagBit))
    else $error("flag codes 0 to 4 picked the wrong flag");
  a_flag_mid_codes: assert property ((absF || relF) && w[8:5] inside {[4'h5:4'h8]} |=> pcUpdate.taken == $past(flagBit))
    else $error("flag codes 5 to 8 picked the wrong flag");
  a_flag_high_codes: assert property ((absF || relF) && w[8:5] >= 4'h9 ##1 pcUpdate.valid |-> pcUpdate.taken == $past(flagBit))
    else $error("flag codes 9 to 15 picked the wrong flag");
  a_rel_target: assert property (relF && flagBit |=> pcUpdate.taken && pcUpdate.next == $past(relNext))
    else $error("relative jump target wrong");
  a_abs_flag_kind: assert property (absF |=> pcUpdate.valid && pcUpdate.kind == KIND_ABS_FLAG)
    else $error("absolute flag jump not decoded");
  a_rel_flag_kind: assert property (relF |-> ##1 pcUpdate.kind == KIND_REL_FLAG)
    else $error("relative flag jump not decoded");
  a_ctrl_target: assert property (absC |=> !pcUpdate.taken || pcUpdate.next == $past(jreg))
    else $error("control bit jump target wrong");
  a_ctrl_kind: assert property (absC |=> pcUpdate.kind == KIND_ABS_CTRL)
    else $error("control bit jump not decoded");
  a_seq_next: assert property (instrIn.valid ##1 !pcUpdate.taken |-> pcUpdate.next == $past(instrIn.addr) + 10'h001)
    else $error("untaken jump did not fall through");
  a_wait_answer: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("bus request not answered after one wait cycle");
  a_wait_single: assert property (!avsWaitrequest |=> avsWaitrequest)
    else $error("waitrequest stayed low for more than one cycle");
  a_pc_idle: assert property (!instrIn.valid |=> pcUpdate == '0)
    else $error("program counter update without an instruction");

  c_abs_taken: cover property (absF && flagBit ##1 pcUpdate.taken);
  c_rel_taken: cover property (relF && flagBit ##1 pcUpdate.taken);
  c_ctrl_taken: cover property (absC ##1 pcUpdate.taken);
  c_bus_read: cover property (avsRead && !avsWaitrequest);
endmodule

bind ucj_jump_unit ucj_jump_unit_assertions u_chk (.clk, .sys_rst, .instrIn, .aluFlags, .jumpRegs, .pcUpdate,
  .avsAddress, .avsRead, .avsWrite, .avsWritedata, .avsByteenable, .avsReaddata, .avsWaitrequest);

// ==== testbench.sv ====
// Self-checking bench for the conditional jump unit.
// Assumes ucj_fetch_model feeds instructions and the checker is bound to the DUT.
`timescale 1ns/1ps
module testbench;
  import ucj_pkg::*;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  ucj_instr_type     cmd = '0;
  ucj_instr_type     instrIn;
  ucj_alu_flags_type aluFlags = '0;
  ucj_jump_regs_type jumpRegs = {10'h3C5, 10'h0A7};
  ucj_pc_update_type pcUpdate;
  logic [11:0]       avsAddress = '0;
  logic              avsRead = 1'b0;
  logic              avsWrite = 1'b0;
  logic [31:0]       avsWritedata = '0;
  logic [3:0]        avsByteenable = '0;
  logic [31:0]       avsReaddata;
  logic              avsWaitrequest;
  logic [31:0]       rd;
  logic [15:0]       pat;
  logic [9:0]        a;
  logic [9:0]        j;
  logic [4:0]        off;
  logic              tk;
  logic [11:0]       regAddr [5] = '{12'h404, 12'h408, 12'h484, 12'h488, 12'h500};
  int                miscompares = 0;
  int                cmpCount = 0;

  ucj_fetch_model u_fetch (.clk, .cmd, .instrIn);
  ucj_jump_unit #(.CORE_ID(0)) DUT (.clk, .sys_rst, .instrIn, .aluFlags, .jumpRegs, .pcUpdate, .avsAddress,
    .avsRead, .avsWrite, .avsWritedata, .avsByteenable, .avsReaddata, .avsWaitrequest);

  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // The request is held until waitrequest is sampled low; read data is taken at that edge.
  task automatic bus(logic wr, logic [11:0] ad, logic [31:0] d, logic [3:0] be, output logic [31:0] q);
    @(posedge clk);
    avsAddress <= ad;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWritedata <= d;
    avsByteenable <= be;
    // Only the watchdog ends a wait that never sees waitrequest low.
    do begin
      @(posedge clk);
    end while (avsWaitrequest !== 1'b0);
    q = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask

  task automatic jump(logic [15:0] w, logic [9:0] ad, logic [15:0] f, logic t, logic [1:0] k, logic [9:0] nx);
    @(posedge clk);
    cmd <= '{1'b1, w, ad};
    aluFlags <= f;
    @(posedge clk);
    cmd <= '0;
    #1;
    check("pcUpdate", 32'(pcUpdate), 32'({1'b1, t, k, nx}));
  endtask

  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (regAddr[i]) begin
      bus(1'b0, regAddr[i], '0, 4'hF, rd);
      check("reset value", rd, 32'h0000_0000);
    end
    for (int i = 0; i < 5; i++) bus(1'b1, regAddr[i], 32'hFFFF_1357 + i, 4'hF, rd);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, regAddr[i], '0, 4'hF, rd);
      check("register readback", rd, i == 4 ? 32'h0000_0000 : 32'h0000_1357 + i);
    end
    bus(1'b1, 12'h404, 32'h0000_FFFF, 4'h2, rd);
    bus(1'b0, 12'h404, '0, 4'hF, rd);
    check("byte lane write", rd, 32'h0000_FF57);
    bus(1'b1, 12'h600, 32'h0000_FFFF, 4'hF, rd);
    bus(1'b0, 12'h600, '0, 4'hF, rd);
    check("unmapped read", rd, 32'h0000_0000);
    bus(1'b0, 12'h405, '0, 4'hF, rd);
    check("misaligned read", rd, 32'h0000_0000);
    $display("test registers done");
    for (int n = 0; n < 16; n++) begin
      a = 10'(n * 37);
      j = n[0] ? jumpRegs.jump1 : jumpRegs.jump0;
      jump({7'h1D, 4'(n), n[0], 4'h5}, a, 16'(1 << n), 1'b1, KIND_ABS_FLAG, j);
      jump({7'h1D, 4'(n), n[0], 4'h5}, a, ~16'(1 << n), 1'b0, KIND_ABS_FLAG, a + 10'h001);
    end
    $display("test absolute flag jump done");
    for (int n = 0; n < 16; n++) begin
      a = 10'h3F8 + 10'(n);
      off = n[0] ? 5'h0F : 5'h10;
      jump({7'h12, 4'(n), off}, a, 16'(1 << n), 1'b1, KIND_REL_FLAG, a + {{5{off[4]}}, off});
      jump({7'h12, 4'(n), off}, a, ~16'(1 << n), 1'b0, KIND_REL_FLAG, a + 10'h001);
    end
    $display("test relative flag jump done");
    pat = 16'hA5C3;
    bus(1'b1, 12'h404, {16'h0000, pat}, 4'hF, rd);
    bus(1'b1, 12'h408, {16'h0000, ~pat}, 4'hF, rd);
    bus(1'b1, 12'h484, {16'h0000, ~pat}, 4'hF, rd);
    for (int n = 0; n < 32; n++) begin
      a = 10'(n * 29);
      tk = pat[n[3:0]] == n[4];
      j = n[1] ? jumpRegs.jump1 : jumpRegs.jump0;
      jump({6'h0F, n[4], n[3:0], n[1], 4'h4}, a, 16'hFFFF, tk, KIND_ABS_CTRL, tk ? j : a + 10'h001);
    end
    $display("test control bit jump done");
    jump({7'h1D, 4'h1, 1'b0, 4'h4}, 10'h010, 16'hFFFF, 1'b0, KIND_NONE, 10'h011);
    jump({7'h13, 4'h1, 5'h03}, 10'h020, 16'hFFFF, 1'b0, KIND_NONE, 10'h021);
    jump({6'h0F, 1'b0, 4'h1, 1'b0, 4'h5}, 10'h030, 16'hFFFF, 1'b0, KIND_NONE, 10'h031);
    $display("test near miss decode done");
    jump({7'h1D, 4'h0, 1'b1, 4'h5}, 10'h100, 16'h0001, 1'b1, KIND_ABS_FLAG, jumpRegs.jump1);
    @(posedge clk);
    #1;
    check("pcUpdate idle", 32'(pcUpdate), 32'h0000_0000);
    bus(1'b0, 12'h500, '0, 4'hF, rd);
    check("status", rd, {6'h00, jumpRegs.jump1, 12'h000, 2'b01, 2'b11});
    $display("test status done");
    stop_test();
  end

  // Whole run needs about 1.4 us; a stuck handshake ends it here.
  initial begin
    #20000;
    miscompares++;
    stop_test();
  end
endmodule
